// >>> src/wdrc_cfg.svh
`ifndef WDRC_CFG_SVH
`define WDRC_CFG_SVH

// register offsets in port space, and the data-space window
`define WDRC_CTRL_OFF 6'h21
`define WDRC_FLAGS_OFF 6'h34
`define WDRC_IO_LAST 7'h3f
`define WDRC_DATA_BASE 7'h20
`define WDRC_DATA_LAST 7'h5f

// field positions
`define WDRC_CHG_BIT 4
`define WDRC_WDE_BIT 3
`define WDRC_PS_MSB 2
`define WDRC_WATCHDOG_RESET_FLAG_BIT 3
`define WDRC_BROWNOUT_RESET_FLAG_BIT 2
`define WDRC_EXTERNAL_RESET_FLAG_BIT 1
`define WDRC_POWERON_RESET_FLAG_BIT 0

// reset values
`define WDRC_CTRL_RESET 5'h00
`define WDRC_FLAGS_RESET 4'h0
`define WDRC_RDATA_RESET 8'h00

// timing counts
`define WDRC_CHG_WINDOW 3'h4
`define WDRC_TIMEOUT_BASE 22'h00_4000

`endif

// >>> src/wdrc_pkg.sv
package wdrc_pkg;

  // one register access from the cpu core
  typedef struct packed {
    logic rd;
    logic wr;
    logic data_space;
    logic [6:0] addr;
    logic [7:0] wdata;
  } wdrc_bus_req_type;

  // watchdog control register content
  typedef struct packed {
    logic change_en;
    logic enable;
    logic [2:0] prescale;
  } wdrc_ctrl_type;

  // state of the timed change window
  typedef enum logic [1:0] {
    WDRC_WIN_CLOSED = 2'b01,
    WDRC_WIN_OPEN = 2'b10
  } wdrc_win_type;

endpackage

// >>> src/wdrc_sync.sv
`timescale 1ns/10ps
module wdrc_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // two flip-flops per pin; only the second stage is read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (ce_i) begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule

// >>> src/wdrc_wdt_core.sv
`timescale 1ns/10ps
`include "wdrc_cfg.svh"
module wdrc_wdt_core #(
  parameter logic [21:0] TIMEOUT_BASE_CYCLES = `WDRC_TIMEOUT_BASE
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic osc_tick_i,
  input wire logic restart_i,
  input wire logic enable_i,
  input wire logic [2:0] prescale_i,
  output logic timeout_o
);
  logic [21:0] count_reg;
  logic [21:0] count_next;
  logic [21:0] limit;
  logic timeout_reg;
  logic timeout_next;
  logic reach;

  // time-out length doubles with each prescale code
  assign limit = TIMEOUT_BASE_CYCLES << prescale_i;
  // >= so that a shorter limit set mid-count still fires
  assign reach = osc_tick_i && (count_reg >= (limit - 22'h00_0001));

  // count oscillator ticks, restart, or fire
  always_comb begin
    count_next = count_reg;
    timeout_next = 1'b0;
    if (restart_i || !enable_i) begin
      count_next = '0;
    end else if (reach) begin
      count_next = '0;
      timeout_next = 1'b1;
    end else if (osc_tick_i) begin
      count_next = count_reg + 22'h00_0001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= '0;
      timeout_reg <= 1'b0;
    end else if (ce_i) begin
      count_reg <= count_next;
      timeout_reg <= timeout_next;
    end
  end

  assign timeout_o = timeout_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  cnt_restart_a: assert property ((ce_i && (restart_i || !enable_i)) |=> count_reg == '0)
    else $error("count not cleared by restart or disable");
  cnt_fire_a: assert property ((ce_i && reach && !restart_i && enable_i) |=> timeout_reg)
    else $error("time-out not raised at selected count");
  cnt_quiet_a: assert property ((ce_i && !reach) |=> !timeout_reg)
    else $error("time-out raised before selected count");
endmodule

// >>> src/wdrc_top.sv
`timescale 1ns/10ps
`include "wdrc_cfg.svh"
// Overview of operation
// - watchdog reset sets bit 3, zero-write clears
// - brown-out reset sets bit 2, zero-write clears
// - external reset sets bit 1, zero-write clears
// - power-on sets bit 0, only zero-write clears
// - port offsets 0x00-0x3F, data space plus 0x20
// - change-enable clears itself four cycles later
// - enable bit one enables, permitted zero disables
// - zero to enable ignored without change-enable
// - prescale written only while change-enable set, chip reset zeroes it
// - prescale selects 16384 doubling to 2097152 cycles
// - time-out gives one-cycle internal reset pulse
// - count restarts on restart, disable, chip reset
// - always-on fuse keeps watchdog enabled, reads one
// - counter runs from separate oscillator ticks
module wdrc_top #(
  parameter logic [21:0] TIMEOUT_BASE_CYCLES = `WDRC_TIMEOUT_BASE
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire wdrc_pkg::wdrc_bus_req_type BUS_REQ_I,
  input wire logic RESTART_I,
  input wire logic WDT_OSC_I,
  input wire logic EXT_RESET_I,
  input wire logic BROWNOUT_I,
  input wire logic ALWAYS_ON_FUSE_I,
  output logic [7:0] RDATA_O,
  output logic WDT_RESET_O,
  output logic WDT_ACTIVE_O
);
  import wdrc_pkg::*;

  logic [3:0] pins_sync;
  logic osc_s;
  logic ext_s;
  logic bor_s;
  logic fuse_s;
  logic osc_d_reg;
  logic osc_tick;
  logic [6:0] addr;
  logic [6:0] io_off_full;
  logic [5:0] io_off;
  logic in_range;
  logic hit_ctrl;
  logic hit_flags;
  logic wr_ctrl;
  logic wr_flags;
  logic rd_go;
  logic wd_chg;
  logic wd_wde;
  logic [2:0] wd_ps;
  logic open_req;
  logic chg_en;
  logic wde_eff;
  logic wdt_timeout;
  logic chip_rst;
  logic core_restart;
  wdrc_win_type win_reg;
  wdrc_win_type win_next;
  logic [2:0] win_cnt_reg;
  logic [2:0] win_cnt_next;
  wdrc_ctrl_type ctrl_reg;
  wdrc_ctrl_type ctrl_next;
  wdrc_ctrl_type ctrl_view;
  logic [3:0] flags_reg;
  logic [3:0] flags_next;
  logic [3:0] flag_set;
  logic por_pend_reg;
  logic [7:0] rd_value;
  logic [7:0] rdata_reg;

  // reset sources, fuse and oscillator cross in through two flops
  wdrc_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .async_i({ALWAYS_ON_FUSE_I, BROWNOUT_I, EXT_RESET_I, WDT_OSC_I}),
    .sync_o(pins_sync)
  );

  assign osc_s = pins_sync[0];
  assign ext_s = pins_sync[1];
  assign bor_s = pins_sync[2];
  assign fuse_s = pins_sync[3];

  // rising edge of the synchronised oscillator is one watchdog tick
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      osc_d_reg <= 1'b0;
    end else if (CE_I) begin
      osc_d_reg <= osc_s;
    end
  end

  assign osc_tick = osc_s && !osc_d_reg;

  // address decode for port space and the shifted data space
  assign addr = BUS_REQ_I.addr;
  assign in_range = BUS_REQ_I.data_space ?
    ((addr >= `WDRC_DATA_BASE) && (addr <= `WDRC_DATA_LAST)) :
    (addr <= `WDRC_IO_LAST);
  assign io_off_full = BUS_REQ_I.data_space ? (addr - `WDRC_DATA_BASE) : addr;
  assign io_off = io_off_full[5:0];
  assign hit_ctrl = in_range && (io_off == `WDRC_CTRL_OFF);
  assign hit_flags = in_range && (io_off == `WDRC_FLAGS_OFF);

  // qualified strobes and write fields
  assign wr_ctrl = CE_I && BUS_REQ_I.wr && hit_ctrl;
  assign wr_flags = CE_I && BUS_REQ_I.wr && hit_flags;
  assign rd_go = CE_I && BUS_REQ_I.rd;
  assign wd_chg = BUS_REQ_I.wdata[`WDRC_CHG_BIT];
  assign wd_wde = BUS_REQ_I.wdata[`WDRC_WDE_BIT];
  assign wd_ps = BUS_REQ_I.wdata[`WDRC_PS_MSB:0];

  // any chip reset other than power-on
  assign chip_rst = ext_s || bor_s || wdt_timeout;
  assign open_req = wr_ctrl && wd_chg && wd_wde;
  assign chg_en = (win_reg == WDRC_WIN_OPEN);

  // timed change window: opens on a one-one write, lasts four cycles
  always_comb begin
    win_next = win_reg;
    win_cnt_next = win_cnt_reg;
    if (chip_rst) begin
      win_next = WDRC_WIN_CLOSED;
      win_cnt_next = 3'h0;
    end else if (open_req) begin
      win_next = WDRC_WIN_OPEN;
      win_cnt_next = `WDRC_CHG_WINDOW;
    end else begin
      case (win_reg)
        WDRC_WIN_OPEN: begin
          if (wr_ctrl && !wd_chg) begin
            win_next = WDRC_WIN_CLOSED;
            win_cnt_next = 3'h0;
          end else if (win_cnt_reg == 3'h1) begin
            win_next = WDRC_WIN_CLOSED;
            win_cnt_next = 3'h0;
          end else begin
            win_cnt_next = win_cnt_reg - 3'h1;
          end
        end
        WDRC_WIN_CLOSED: begin
          win_cnt_next = 3'h0;
        end
        default: begin
          win_next = WDRC_WIN_CLOSED;
          win_cnt_next = 3'h0;
        end
      endcase
    end
  end

  // enable and prescale, guarded by the window
  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next.change_en = (win_next == WDRC_WIN_OPEN);
    if (chip_rst) begin
      ctrl_next = `WDRC_CTRL_RESET;
    end else if (wr_ctrl) begin
      if (wd_wde) begin
        ctrl_next.enable = 1'b1;
      end else if (chg_en) begin
        ctrl_next.enable = 1'b0;
      end
      if (chg_en) begin
        ctrl_next.prescale = wd_ps;
      end
    end
  end

  // the fuse forces the watchdog on regardless of the stored bit
  assign wde_eff = ctrl_reg.enable || fuse_s;

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      win_reg <= WDRC_WIN_CLOSED;
      win_cnt_reg <= 3'h0;
      ctrl_reg <= `WDRC_CTRL_RESET;
    end else if (CE_I) begin
      win_reg <= win_next;
      win_cnt_reg <= win_cnt_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // watchdog counter on the oscillator tick
  assign core_restart = RESTART_I || chip_rst;

  wdrc_wdt_core #(
    .TIMEOUT_BASE_CYCLES(TIMEOUT_BASE_CYCLES)
  ) u_core (
    .clk_i(REF_CLK_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .osc_tick_i(osc_tick),
    .restart_i(core_restart),
    .enable_i(wde_eff),
    .prescale_i(ctrl_reg.prescale),
    .timeout_o(wdt_timeout)
  );

  // reset-cause flags: set wins over a software zero
  assign flag_set[`WDRC_WATCHDOG_RESET_FLAG_BIT] = wdt_timeout;
  assign flag_set[`WDRC_BROWNOUT_RESET_FLAG_BIT] = bor_s;
  assign flag_set[`WDRC_EXTERNAL_RESET_FLAG_BIT] = ext_s;
  assign flag_set[`WDRC_POWERON_RESET_FLAG_BIT] = por_pend_reg;

  for (genvar i = 0; i < 4; i++) begin : g_flag
    assign flags_next[i] = flag_set[i] ||
      (wr_flags ? BUS_REQ_I.wdata[i] : flags_reg[i]);
  end

  // power-on clears all flags, then marks itself after release
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      flags_reg <= `WDRC_FLAGS_RESET;
      por_pend_reg <= 1'b1;
    end else if (CE_I) begin
      flags_reg <= flags_next;
      por_pend_reg <= 1'b0;
    end
  end

  // read mux; unused bits and unmapped offsets read zero
  always_comb begin
    ctrl_view = ctrl_reg;
    ctrl_view.change_en = chg_en;
    ctrl_view.enable = wde_eff;
  end

  assign rd_value = hit_ctrl ? {3'h0, ctrl_view} :
    (hit_flags ? {4'h0, flags_reg} : 8'h00);

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_reg <= `WDRC_RDATA_RESET;
    end else if (rd_go) begin
      rdata_reg <= rd_value;
    end
  end

  assign RDATA_O = rdata_reg;
  assign WDT_RESET_O = wdt_timeout;
  assign WDT_ACTIVE_O = wde_eff;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  chg_window_open_a: assert property ((open_req && !chip_rst) |=> chg_en)
    else $error("change window did not open");
  chg_window_close_a: assert property (
    (open_req && !chip_rst) ##1 (CE_I && !wr_ctrl && !chip_rst) [*4] |=> !chg_en)
    else $error("change window not closed after four cycles");
  chg_window_hold_a: assert property (
    (open_req && !chip_rst) ##1 (CE_I && !wr_ctrl && !chip_rst) [*3] |=> chg_en)
    else $error("change window closed early");
  wde_set_a: assert property ((wr_ctrl && wd_wde && !chip_rst) |=> ctrl_reg.enable)
    else $error("enable write of one not taken");
  wde_clear_a: assert property (
    (wr_ctrl && !wd_wde && chg_en && !chip_rst) |=> !ctrl_reg.enable)
    else $error("permitted disable not taken");
  wde_guard_a: assert property (
    (wr_ctrl && !wd_wde && !chg_en && ctrl_reg.enable && !chip_rst) |=> ctrl_reg.enable)
    else $error("unguarded disable was taken");
  prescale_lock_a: assert property (
    (CE_I && !chg_en && !chip_rst) |=> $stable(ctrl_reg.prescale))
    else $error("prescale changed outside window");
  fuse_read_a: assert property ((rd_go && hit_ctrl && fuse_s) |=> RDATA_O[`WDRC_WDE_BIT])
    else $error("enable bit read zero with fuse set");
  watchdog_reset_flag_set_a: assert property ((CE_I && wdt_timeout) |=> flags_reg[`WDRC_WATCHDOG_RESET_FLAG_BIT])
    else $error("watchdog flag not set on time-out");
  brownout_reset_flag_set_a: assert property ((CE_I && bor_s) |=> flags_reg[`WDRC_BROWNOUT_RESET_FLAG_BIT])
    else $error("brown-out flag not set");
  external_reset_flag_set_a: assert property ((CE_I && ext_s) |=> flags_reg[`WDRC_EXTERNAL_RESET_FLAG_BIT])
    else $error("external flag not set");
  poweron_reset_flag_keep_a: assert property (
    (flags_reg[`WDRC_POWERON_RESET_FLAG_BIT] && !(wr_flags && !BUS_REQ_I.wdata[`WDRC_POWERON_RESET_FLAG_BIT]))
      |=> flags_reg[`WDRC_POWERON_RESET_FLAG_BIT])
    else $error("power-on flag lost without zero write");
  pulse_len_a: assert property ((CE_I && WDT_RESET_O) |=> !WDT_RESET_O)
    else $error("watchdog reset pulse longer than one cycle");
  data_alias_a: assert property (
    (BUS_REQ_I.data_space && addr == 7'h41) |-> hit_ctrl)
    else $error("data-space alias of control not decoded");

  disable_seq_c: cover property (open_req ##[1:4] (wr_ctrl && !wd_wde && chg_en));
  timeout_c: cover property (WDT_RESET_O ##1 flags_reg[`WDRC_WATCHDOG_RESET_FLAG_BIT]);
  prescale_change_c: cover property (wr_ctrl && chg_en && wd_ps != ctrl_reg.prescale);
  poweron_reset_flag_clear_c: cover property (wr_flags && !BUS_REQ_I.wdata[0] && flags_reg[0]);
endmodule

// >>> testbench/wdrc_top_test.sv
`timescale 1ns/10ps
module wdrc_top_test;
  import wdrc_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic ce = 1;
  logic rs = 0;
  logic osc = 0;
  logic ext = 0;
  logic bor = 0;
  logic fuse = 0;
  wdrc_bus_req_type req = '0;
  logic [7:0] rdata;
  logic wdt_rst;
  logic act;
  int miscompares = 0;
  int compares = 0;
  int win = 0;
  int cm = 0;
  int fm = 1;
  int hits;
  int first;
  logic [31:0] seed = 32'hb09f_2761;

  wdrc_top #(.TIMEOUT_BASE_CYCLES(22'h00_0004)) wdrc_top_i (.REF_CLK_I(clk), .RESET_I(rst),
    .CE_I(ce), .BUS_REQ_I(req), .RESTART_I(rs), .WDT_OSC_I(osc), .EXT_RESET_I(ext),
    .BROWNOUT_I(bor), .ALWAYS_ON_FUSE_I(fuse), .RDATA_O(rdata), .WDT_RESET_O(wdt_rst),
    .WDT_ACTIVE_O(act));

  // system clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end

  // xorshift source for random write data
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one bus cycle; the model ages its change window on every edge
  task automatic put(logic r, logic w, logic ds, logic [6:0] a, logic [7:0] d);
    @(posedge clk);
    if (win > 0) begin
      win--;
      if (win == 0) cm &= 8'h0f;
    end
    req <= '{rd: r, wr: w, data_space: ds, addr: a, wdata: d};
  endtask

  task automatic idle(int n);
    repeat (n) put(0, 0, 0, 7'h00, 8'h00);
  endtask

  // register write, mirrored into the model
  task automatic wreg(logic [6:0] a, logic [7:0] d, logic ds = 0);
    put(0, 1, ds, a, d);
    if (a == (ds ? 7'h41 : 7'h21)) begin
      cm = {d[4] & d[3], (d[3] || win > 0) ? d[3] : cm[3], win > 0 ? d[2:0] : 3'(cm)};
      win = (d[4] & d[3]) ? 5 : 0;
    end
    if (a == (ds ? 7'h54 : 7'h34)) fm = d & 8'h0f;
  endtask

  // register read compared with the model
  task automatic rreg(logic [6:0] a, logic ds = 0);
    logic [7:0] exp;
    put(1, 0, ds, a, 8'h00);
    exp = 8'h00;
    if (a == (ds ? 7'h41 : 7'h21)) exp = 8'(cm) | {4'h0, fuse, 3'h0};
    if (a == (ds ? 7'h54 : 7'h34)) exp = 8'(fm);
    idle(1);
    #1;
    check($sformatf("reg_%h", a), rdata, exp);
  endtask

  // n oscillator periods of 20 system cycles; optional restart on even ticks
  task automatic ticks(int n, bit kick);
    hits = 0;
    first = 0;
    for (int k = 1; k <= n; k++) begin
      for (int c = 0; c < 20; c++) begin
        idle(1);
        osc <= (c < 10);
        rs <= kick && c == 0 && k % 2 == 0;
        #1;
        if (wdt_rst === 1'b1) begin
          hits++;
          if (first == 0) first = k;
          cm = 0;
          win = 0;
          fm |= 8;
        end
      end
    end
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    idle(2);
    rreg(7'h34); // por flag
    rreg(7'h54, 1); // data space view
    rreg(7'h40); // unmapped port
    rreg(7'h10, 1); // unmapped data
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wreg(7'h34, seed[7:0]);
      rreg(7'h34); // flag store
    end
    wreg(7'h34, 8'h00);
    rreg(7'h34); // por clear
    wreg(7'h21, 8'h08);
    idle(1);
    #1;
    check("active", act, 1); // enable
    wreg(7'h21, 8'h03);
    rreg(7'h21); // locked write
    for (int gap = 3; gap <= 4; gap++) begin
      wreg(7'h41, 8'h18, 1);
      idle(gap);
      rreg(7'h21); // window close
    end
    wreg(7'h21, 8'h18);
    idle(4);
    wreg(7'h21, 8'h00);
    rreg(7'h21); // late zero
    wreg(7'h21, 8'h18);
    idle(3);
    wreg(7'h21, 8'h01);
    rreg(7'h21); // disable
    check("active", act, 0); // disabled
    for (int p = 0; p < 3; p++) begin
      wreg(7'h21, 8'h08);
      wreg(7'h21, 8'h18);
      wreg(7'h21, 8'(8 + p));
      rreg(7'h21); // prescale taken, window closed by the write
      ticks((4 << p) + 2, 0);
      check("pulses", hits, 1); // one pulse
      check("tick", first >= (4 << p) && first <= (4 << p) + 1, 1); // length
      rreg(7'h34); // watchdog flag
      rreg(7'h21); // cleared
      wreg(7'h34, 8'h00);
    end
    wreg(7'h21, 8'h08);
    ticks(10, 1);
    check("pulses", hits, 0); // restarted
    wreg(7'h21, 8'h18);
    wreg(7'h21, 8'h00);
    ticks(10, 0);
    check("pulses", hits, 0); // disabled
    for (int i = 0; i < 2; i++) begin
      wreg(7'h21, 8'h08);
      {bor, ext} <= i ? 2'b10 : 2'b01;
      idle(4);
      {bor, ext} <= 2'b00;
      idle(4);
      fm |= 2 << i;
      cm = 0;
      win = 0;
      rreg(7'h34); // source flag
      rreg(7'h21); // chip reset
      wreg(7'h34, 8'h00);
    end
    idle(1);
    ce <= 0;
    put(0, 1, 0, 7'h34, 8'h0f);
    idle(1);
    ce <= 1;
    rreg(7'h34); // write ignored while frozen
    fuse <= 1;
    idle(3);
    #1;
    check("active", act, 1); // fuse on
    wreg(7'h21, 8'h00);
    rreg(7'h21); // reads one
    fuse <= 0;
    idle(3);
    wreg(7'h34, 8'h0e);
    rreg(7'h34); // flags stored before power-on
    idle(1);
    rst <= 1;
    idle(2);
    rst <= 0;
    fm = 1;
    cm = 0;
    win = 0;
    idle(2);
    rreg(7'h34); // power-on clears
    end_of_test();
  end
endmodule
